// >>> core/cme_exec.sv
// Parallel character move and translate execution unit
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cme_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [cme_pkg::ADDR_W-1:0] mem_addr,
  output logic [cme_pkg::WORD_W-1:0] mem_wdata,
  input wire logic [cme_pkg::WORD_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic brm_valid,
  output logic [cme_pkg::ADDR_W-1:0] brm_addr
);
  cme_pkg::cme_regs_t r_ff;
  cme_pkg::cme_regs_t nxt_r;
  logic [23:0] mr_result;
  logic [cme_pkg::ADDR_W-1:0] tab_addr;
  logic [cme_pkg::ADDR_W-1:0] ptr_step;
  logic [cme_pkg::ADDR_W-1:0] rd_addr;
  logic [23:0] tword;
  logic acc_phase;
  logic wr_take;
  logic rd_take;
  logic idle;

  // =====================================================
  // Register map decode
  function automatic logic map_hit(input logic [7:0] a);
    logic hit;
    unique case (a)
      cme_pkg::REG_CMD, cme_pkg::REG_EA: hit = 1'b1;
      cme_pkg::REG_ACC, cme_pkg::REG_B: hit = 1'b1;
      cme_pkg::REG_X3, cme_pkg::REG_STAT: hit = 1'b1;
      cme_pkg::REG_BRA: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : map_hit

  // =====================================================
  // Memory request builders
  function automatic cme_pkg::cme_mem_t mem_rd(
      input logic [cme_pkg::ADDR_W-1:0] a);
    cme_pkg::cme_mem_t m;
    m.req = 1'b1;
    m.we = 1'b0;
    m.addr = a;
    m.wdata = cme_pkg::WORD_RST;
    return m;
  endfunction : mem_rd

  function automatic cme_pkg::cme_mem_t mem_wr(
      input logic [cme_pkg::ADDR_W-1:0] a,
      input logic [cme_pkg::WORD_W-1:0] d);
    cme_pkg::cme_mem_t m;
    m.req = 1'b1;
    m.we = 1'b1;
    m.addr = a;
    m.wdata = d;
    return m;
  endfunction : mem_wr

  // =====================================================
  // Datapath helpers
  cme_merge_rot u_merge_rot (
    .first_word(r_ff.acc),
    .second_word(r_ff.b),
    .ctl(r_ff.ctl),
    .left_mode(r_ff.op == cme_pkg::OP_LPL),
    .result(mr_result)
  );

  cme_addr_add #(
    .ADDR_W(cme_pkg::ADDR_W)
  ) u_addr_add (
    .base(r_ff.tp),
    .char_byte(r_ff.b[23:16]),
    .sum(tab_addr)
  );

  // =====================================================
  // Address and handshake decode
  assign ptr_step = (r_ff.op == cme_pkg::OP_LPL) ?
                    cme_pkg::ADDR_W'(r_ff.ptr - 1'b1) :
                    cme_pkg::ADDR_W'(r_ff.ptr + 1'b1);
  assign rd_addr = mem_rdata[cme_pkg::ADDR_W-1:0];
  assign acc_phase = psel && penable && !r_ff.pready;
  assign wr_take = psel && penable && r_ff.pready && pwrite;
  assign rd_take = acc_phase && !pwrite;
  assign idle = r_ff.st == cme_pkg::ST_IDLE;
  assign tword = mem_rdata;

  // =====================================================
  // Next state
  always_comb begin
    nxt_r = r_ff;
    nxt_r.brm_valid = 1'b0;
    // =====================================================
    // Bus answer after one wait state
    nxt_r.pready = acc_phase;
    nxt_r.pslverr = acc_phase && !map_hit(paddr);
    // =====================================================
    // Register read
    if (rd_take) begin
      // Upper bits read as zero
      nxt_r.prdata = 32'h00000000;
      unique case (paddr)
        cme_pkg::REG_CMD: begin
          nxt_r.prdata[1:0] = r_ff.op;
        end
        cme_pkg::REG_EA: begin
          nxt_r.prdata[14:0] = r_ff.ea;
        end
        cme_pkg::REG_ACC: begin
          nxt_r.prdata[23:0] = r_ff.acc;
        end
        cme_pkg::REG_B: begin
          nxt_r.prdata[23:0] = r_ff.b;
        end
        cme_pkg::REG_X3: begin
          nxt_r.prdata[23:0] = r_ff.x3;
        end
        cme_pkg::REG_STAT: begin
          nxt_r.prdata[cme_pkg::STAT_BUSY_BIT] = !idle;
          nxt_r.prdata[cme_pkg::STAT_BRM_BIT] = r_ff.brm_flag;
        end
        cme_pkg::REG_BRA: begin
          nxt_r.prdata[14:0] = r_ff.brm_addr;
        end
        default: begin
          nxt_r.prdata = 32'h00000000;
        end
      endcase
    end
    // =====================================================
    // Register write, only while idle
    if (wr_take && idle) begin
      unique case (paddr)
        cme_pkg::REG_CMD: begin
          nxt_r.op = pwdata[1:0];
          if (pwdata[cme_pkg::CMD_GO_BIT]) begin
            nxt_r.st = cme_pkg::ST_RUN;
            nxt_r.step = 3'h0;
            nxt_r.brm_flag = 1'b0;
            // Translation starts at the table base
            if (pwdata[1:0] == cme_pkg::OP_TRT) begin
              nxt_r.x3 = cme_pkg::WORD_RST;
              nxt_r.tp = r_ff.ea;
            end
          end
        end
        cme_pkg::REG_EA: begin
          nxt_r.ea = pwdata[14:0];
        end
        cme_pkg::REG_ACC: begin
          nxt_r.acc = pwdata[23:0];
        end
        cme_pkg::REG_B: begin
          nxt_r.b = pwdata[23:0];
        end
        cme_pkg::REG_X3: begin
          nxt_r.x3 = pwdata[23:0];
        end
        default: begin
          nxt_r.acc = r_ff.acc;
        end
      endcase
    end
    // =====================================================
    // Sequencer: issue an access, then take its answer
    unique case (r_ff.st)
      cme_pkg::ST_IDLE: begin
        nxt_r.mem.req = 1'b0;
      end
      cme_pkg::ST_RUN: begin
        // Launch the access of this step
        nxt_r.st = cme_pkg::ST_WAIT;
        unique case (r_ff.op)
          cme_pkg::OP_LPR, cme_pkg::OP_LPL: begin
            // Pointer and control words first, then data
            unique case (r_ff.step)
              3'h0: begin
                nxt_r.mem = mem_rd(cme_pkg::ADDR_W'(r_ff.ea + 1'b1));
              end
              3'h1: begin
                nxt_r.mem = mem_rd(r_ff.ea);
              end
              3'h2: begin
                nxt_r.mem = mem_rd(cme_pkg::ADDR_W'(r_ff.tp + 1'b1));
              end
              3'h3: begin
                nxt_r.mem = mem_rd(r_ff.ptr);
              end
              3'h4: begin
                nxt_r.mem = mem_rd(ptr_step);
              end
              default: begin
                nxt_r.acc = mr_result;
                nxt_r.mem = mem_wr(cme_pkg::ADDR_W'(r_ff.ea + 1'b1),
                                   {9'h000, ptr_step});
              end
            endcase
          end
          cme_pkg::OP_SPR: begin
            unique case (r_ff.step)
              3'h0: begin
                nxt_r.mem = mem_rd(r_ff.ea);
              end
              3'h1: begin
                nxt_r.mem = mem_wr(r_ff.ptr, r_ff.acc);
              end
              default: begin
                nxt_r.mem = mem_wr(r_ff.ea, {9'h000, ptr_step});
                nxt_r.b = {9'h000, ptr_step};
              end
            endcase
          end
          default: begin
            nxt_r.mem = mem_rd(tab_addr);
          end
        endcase
      end
      cme_pkg::ST_WAIT: begin
        // Take the answer of the finished access
        if (mem_ack) begin
          nxt_r.mem.req = 1'b0;
          nxt_r.mem.we = 1'b0;
          nxt_r.st = cme_pkg::ST_RUN;
          nxt_r.step = 3'(r_ff.step + 1'b1);
          unique case (r_ff.op)
            cme_pkg::OP_LPR, cme_pkg::OP_LPL: begin
              unique case (r_ff.step)
                3'h0: begin
                  nxt_r.ptr = rd_addr;
                end
                3'h1: begin
                  nxt_r.tp = rd_addr;
                end
                3'h2: begin
                  nxt_r.ctl = tword;
                end
                3'h3: begin
                  nxt_r.acc = tword;
                end
                3'h4: begin
                  nxt_r.b = tword;
                end
                default: begin
                  nxt_r.st = cme_pkg::ST_IDLE;
                end
              endcase
            end
            cme_pkg::OP_SPR: begin
              if (r_ff.step == 3'h0) begin
                nxt_r.ptr = rd_addr;
              end else if (r_ff.step == 3'h2) begin
                nxt_r.st = cme_pkg::ST_IDLE;
              end
            end
            default: begin
              nxt_r.step = 3'h0;
              // Odd address field: branch and mark
              if (tword[0]) begin
                nxt_r.brm_valid = 1'b1;
                nxt_r.brm_flag = 1'b1;
                nxt_r.brm_addr = rd_addr;
                nxt_r.st = cme_pkg::ST_IDLE;
              end else begin
                nxt_r.tp = rd_addr;
                nxt_r.acc = cme_pkg::WORD_W'(r_ff.acc + tword);
                nxt_r.b = {r_ff.b[15:0], tword[23:16]};
                if (r_ff.x3[1:0] == cme_pkg::LAST_PASS) begin
                  nxt_r.x3 = tword;
                  nxt_r.st = cme_pkg::ST_IDLE;
                end else begin
                  nxt_r.x3 = cme_pkg::WORD_W'(r_ff.x3 + 1'b1);
                end
              end
            end
          endcase
        end
      end
      default: nxt_r.st = cme_pkg::ST_IDLE;
    endcase
    // Busy output follows the next state
    nxt_r.busy = nxt_r.st != cme_pkg::ST_IDLE;
  end

  // =====================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff <= '{st: cme_pkg::ST_IDLE,
                op: cme_pkg::OP_LPR,
                step: 3'h0,
                ea: 15'h0000,
                acc: cme_pkg::WORD_RST,
                b: cme_pkg::WORD_RST,
                x3: cme_pkg::WORD_RST,
                ptr: 15'h0000,
                tp: 15'h0000,
                ctl: cme_pkg::WORD_RST,
                mem: '{req: 1'b0,
                       we: 1'b0,
                       addr: 15'h0000,
                       wdata: cme_pkg::WORD_RST},
                brm_flag: 1'b0,
                brm_valid: 1'b0,
                brm_addr: 15'h0000,
                busy: 1'b0,
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: 32'h00000000};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // =====================================================
  // Outputs
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign mem_req = r_ff.mem.req;
  assign mem_we = r_ff.mem.we;
  assign mem_addr = r_ff.mem.addr;
  assign mem_wdata = r_ff.mem.wdata;
  assign busy = r_ff.busy;
  assign brm_valid = r_ff.brm_valid;
  assign brm_addr = r_ff.brm_addr;
endmodule : cme_exec
`default_nettype wire

// >>> core/cme_pkg.sv
// Constants and types for the character move and translate unit
// Operation
// - Parallel right loads three bytes into accumulator
// - Right mode: direction, byte control, shift count
// - Load first word, merge bytes, then rotate
// - Controls 0, 0410, 040000610 behave as shown
// - Right load increments pointer, table pointer kept
// - Left load merges lower word, decrements pointer
// - Left mode: suppress bit, byte control, count
// - Left rotate: none, left byte, right byte
// - Controls 040000000, 0110, 0300 behave as shown
// - Left load keeps table pointer, uses B
// - Store writes accumulator, bumps pointer into B
// - Store uses only the second operand pointer
// - Translate looks up three bytes per instruction
// - Table of 256 words from effective address
// - Clear index three, add byte to base
// - Odd address field branches and marks, exits
// - Even address is next base, word summed
// - Replace B byte 0, rotate, bump index
// - Third pass exits, index holds last word
package cme_pkg;
  localparam int WORD_W = 24;
  localparam int ADDR_W = 15;
  localparam int TABLE_ENTRIES = 256;
  // =====================================================
  // Register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_EA = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_B = 8'h0C;
  localparam logic [7:0] REG_X3 = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_BRA = 8'h18;
  localparam int CMD_GO_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BRM_BIT = 1;
  // =====================================================
  // Operations
  localparam logic [1:0] OP_LPR = 2'h0;
  localparam logic [1:0] OP_LPL = 2'h1;
  localparam logic [1:0] OP_SPR = 2'h2;
  localparam logic [1:0] OP_TRT = 2'h3;
  // =====================================================
  // Control word fields, vector bit = 23 - printed bit
  localparam int CTL_DIR_BIT = 23;
  localparam int CTL_BYTE_LSB = 6;
  localparam int CTL_CNT_LSB = 0;
  localparam logic [5:0] BYTE_ROT = 6'h08;
  localparam logic [1:0] LAST_PASS = 2'h2;
  localparam logic [2:0] STEP_LAST = 3'h5;
  localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
  // =====================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_WAIT = 3'b100
  } cme_state_e_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } cme_mem_t;
  typedef struct packed {
    cme_state_e_t st;
    logic [1:0] op;
    logic [2:0] step;
    logic [ADDR_W-1:0] ea;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] b;
    logic [WORD_W-1:0] x3;
    logic [ADDR_W-1:0] ptr;
    logic [ADDR_W-1:0] tp;
    logic [WORD_W-1:0] ctl;
    cme_mem_t mem;
    logic brm_flag;
    logic brm_valid;
    logic [ADDR_W-1:0] brm_addr;
    logic busy;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cme_regs_t;
endpackage : cme_pkg

// >>> core/cme_merge_rot.sv
// Byte merge and rotate stage for the parallel loads
`timescale 1ns/1ps
`default_nettype none
module cme_merge_rot (
  input wire logic [23:0] first_word,
  input wire logic [23:0] second_word,
  input wire logic [23:0] ctl,
  input wire logic left_mode,
  output logic [23:0] result
);
  logic [23:0] merged;
  logic [2:0] sel;
  logic [5:0] cnt;

  function automatic logic [23:0] rotl(input logic [23:0] v,
                                       input logic [5:0] n);
    logic [47:0] t;
    t = {v, v} << n;
    return t[47:24];
  endfunction : rotl

  // =====================================================
  // Merge then rotate
  always_comb begin
    sel = ctl[cme_pkg::CTL_BYTE_LSB +: 3];
    cnt = 6'(ctl[cme_pkg::CTL_CNT_LSB +: 6] % 6'd24);
    merged[23:16] = sel[2] ? second_word[23:16] : first_word[23:16];
    merged[15:8] = sel[1] ? second_word[15:8] : first_word[15:8];
    merged[7:0] = sel[0] ? second_word[7:0] : first_word[7:0];
    if (left_mode) begin
      if (ctl[cme_pkg::CTL_DIR_BIT]) begin
        result = merged;
      end else if (ctl[cme_pkg::CTL_CNT_LSB +: 6] == 6'h00) begin
        result = rotl(merged, cme_pkg::BYTE_ROT);
      end else begin
        result = rotl(merged, 6'h10);
      end
    end else if (ctl[cme_pkg::CTL_DIR_BIT]) begin
      result = rotl(merged, 6'(6'd24 - cnt));
    end else begin
      result = rotl(merged, cnt);
    end
  end
endmodule : cme_merge_rot
`default_nettype wire

// >>> core/cme_addr_add.sv
// Table address adder with carry into the upper address bits
`timescale 1ns/1ps
`default_nettype none
module cme_addr_add #(
  parameter int ADDR_W = 15
) (
  input wire logic [ADDR_W-1:0] base,
  input wire logic [7:0] char_byte,
  output logic [ADDR_W-1:0] sum
);
  // =====================================================
  // Byte added to low bits, carry ripples upward
  always_comb begin
    sum = ADDR_W'(base + {{(ADDR_W-8){1'b0}}, char_byte});
  end
endmodule : cme_addr_add
`default_nettype wire

// >>> sim/cme_exec_chk.sv
// Port checker for the character move and translate unit
`timescale 1ns/1ps
`default_nettype none
module cme_exec_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [cme_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic busy,
  input wire logic brm_valid,
  input wire logic [cme_pkg::ADDR_W-1:0] brm_addr
);
  // ==========
  // Accesses per operation
  logic [3:0] acks_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acks_ff <= 4'h0;
    end else if (!busy) begin
      acks_ff <= 4'h0;
    end else if (mem_ack) begin
      acks_ff <= acks_ff + 4'h1;
    end
  end
  // ==========
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait; mem_req && !mem_ack; endsequence
  sequence s_done; mem_ack ##1 !mem_req; endsequence
  chk_req_hold: assert property (
    s_wait |=> mem_req && $stable(mem_addr))
    else $error("request changed before ack");
  chk_req_drop: assert property (mem_ack |-> s_done)
    else $error("request not dropped after ack");
  chk_req_busy: assert property ($rose(mem_req) |-> busy)
    else $error("access outside an operation");
  chk_op_len: assert property (acks_ff <= 4'h6)
    else $error("too many accesses in one operation");
  chk_brm_pulse: assert property (brm_valid |=> !brm_valid)
    else $error("branch pulse too long");
  chk_brm_odd: assert property (brm_valid |-> brm_addr[0])
    else $error("branch to even address");
  chk_brm_exit: assert property (
    brm_valid |-> ##[0:4] !busy)
    else $error("no exit after branch");
  chk_brm_hold: assert property (
    !brm_valid |=> brm_valid || $stable(brm_addr))
    else $error("branch target moved");
endmodule : cme_exec_chk
bind cme_exec cme_exec_chk cme_exec_chk_inst (.pclk(pclk), .presetn(presetn),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .busy(busy),
  .brm_valid(brm_valid), .brm_addr(brm_addr));
`default_nettype wire

// >>> sim/cme_mem_model.sv
// Word memory answering the unit's access requests
`timescale 1ns/1ps
`default_nettype none
module cme_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [cme_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [cme_pkg::WORD_W-1:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic [cme_pkg::WORD_W-1:0] mem_rdata,
  output logic mem_ack
);
  // ==========
  // Storage and delayed answer
  logic [cme_pkg::WORD_W-1:0] mem [0:511];
  logic [3:0] wait_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 24'h000000;
    end else if (mem_req && !mem_ack && wait_ff >= lat) begin
      mem_ack <= 1'b1;
      wait_ff <= 4'h0;
      mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[8:0]];
      if (mem_we) begin
        mem[mem_addr[8:0]] <= mem_wdata;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_ff <= (mem_req && !mem_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule : cme_mem_model
`default_nettype wire

// >>> sim/cme_exec_tb.sv
// Self-checking bench for the character move and translate unit
`timescale 1ns/1ps
`default_nettype none
module cme_exec_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mem_req, mem_we, mem_ack, busy, brm_valid;
  logic [cme_pkg::ADDR_W-1:0] mem_addr, brm_addr;
  logic [cme_pkg::WORD_W-1:0] mem_wdata, mem_rdata;
  logic [3:0] lat;
  int n_mismatch = 0, compares = 0, brm_cnt = 0;
  cme_exec cme_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy),
    .brm_valid(brm_valid), .brm_addr(brm_addr));
  cme_mem_model cme_mem_model_inst (.pclk(pclk), .presetn(presetn),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .lat(lat),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ==========
  // Clock and helpers
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (brm_valid === 1'b1) brm_cnt++;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h00000000, e);
    check(rd, exp);
  endtask : rdchk
  function automatic void put(input logic [8:0] a, input logic [23:0] d);
    cme_mem_model_inst.mem[a] = d;
  endfunction : put
  task automatic run(input logic [1:0] op, input logic [31:0] ea);
    int n;
    wr(cme_pkg::REG_EA, ea);
    wr(cme_pkg::REG_CMD, 32'h00000100 | {30'h0, op});
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    if (n >= 400) n_mismatch++;
  endtask : run
  task automatic par_case(input logic [1:0] op, input logic [23:0] ctl,
                          input logic [23:0] exp, input logic [8:0] np);
    put(9'h010, 24'h000020);
    put(9'h011, 24'h000040);
    put(9'h021, ctl);
    put(9'h040, 24'h112233);
    put(9'h041, 24'hAABBCC);
    put(9'h03F, 24'hAABBCC);
    run(op, 32'h00000010);
    rdchk(cme_pkg::REG_ACC, {8'h00, exp});
    check({8'h00, cme_mem_model_inst.mem[9'h011]}, {23'h0, np});
    check({8'h00, cme_mem_model_inst.mem[9'h010]}, 32'h00000020);
  endtask : par_case
  // ==========
  // Scenarios
  task automatic test_reset();
    logic e;
    rdchk(cme_pkg::REG_STAT, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000, e);
    check({31'h0, e}, 32'h00000001);
    check(rd, 32'h00000000);
  endtask : test_reset
  task automatic test_lpr();
    par_case(cme_pkg::OP_LPR, 24'h000000, 24'h112233, 9'h041);
    lat <= 4'h3;
    par_case(cme_pkg::OP_LPR, 24'h000108, 24'h2233AA, 9'h041);
    par_case(cme_pkg::OP_LPR, 24'h800188, 24'h33AABB, 9'h041);
  endtask : test_lpr
  task automatic test_lpl();
    par_case(cme_pkg::OP_LPL, 24'h800000, 24'h112233, 9'h03F);
    lat <= 4'h0;
    par_case(cme_pkg::OP_LPL, 24'h000048, 24'hCC1122, 9'h03F);
    par_case(cme_pkg::OP_LPL, 24'h0000C0, 24'hBBCC11, 9'h03F);
  endtask : test_lpl
  task automatic test_spr();
    wr(cme_pkg::REG_ACC, 32'h005A5A5A);
    put(9'h050, 24'h000060);
    put(9'h051, 24'h000070);
    run(cme_pkg::OP_SPR, 32'h00000050);
    check({8'h00, cme_mem_model_inst.mem[9'h060]}, 32'h005A5A5A);
    check({8'h00, cme_mem_model_inst.mem[9'h050]}, 32'h00000061);
    check({8'h00, cme_mem_model_inst.mem[9'h051]}, 32'h00000070);
    rdchk(cme_pkg::REG_B, 32'h00000061);
  endtask : test_spr
  task automatic test_trt_sum();
    lat <= 4'h2;
    wr(cme_pkg::REG_ACC, 32'h00000001);
    wr(cme_pkg::REG_B, 32'h00200102);
    put(9'h110, 24'h4100F0);
    put(9'h0F1, 24'h4200F0);
    put(9'h0F2, 24'h4300F0);
    run(cme_pkg::OP_TRT, 32'h000000F0);
    rdchk(cme_pkg::REG_ACC, 32'h00C602D1);
    rdchk(cme_pkg::REG_B, 32'h00414243);
    rdchk(cme_pkg::REG_X3, 32'h004300F0);
  endtask : test_trt_sum
  task automatic test_trt_branch();
    int b0;
    b0 = brm_cnt;
    wr(cme_pkg::REG_ACC, 32'h00000000);
    wr(cme_pkg::REG_B, 32'h00000300);
    put(9'h0F0, 24'h5100F0);
    put(9'h0F3, 24'h7700A5);
    run(cme_pkg::OP_TRT, 32'h000000F0);
    check({17'h0, brm_addr}, 32'h000000A5);
    rdchk(cme_pkg::REG_X3, 32'h00000001);
    check(brm_cnt - b0, 32'h00000001);
    rdchk(cme_pkg::REG_ACC, 32'h005100F0);
    rdchk(cme_pkg::REG_B, 32'h00030051);
    rdchk(cme_pkg::REG_STAT, 32'h00000002);
  endtask : test_trt_branch
  // ==========
  // Sequence and verdict
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    lat = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_lpr();
    test_lpl();
    test_spr();
    test_trt_sum();
    test_trt_branch();
    give_verdict();
  end
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule : cme_exec_tb
`default_nettype wire
